// file: core/acop_pkg.sv
// constants shared by the converter configuration and output port
package acop_pkg;

    // ************************************************************
    // register offsets (byte addresses, one word each)
    // ************************************************************
    localparam logic [7:0] ACOP_OFS_STATUS   = 8'h00;  // sticky events, read only
    localparam logic [7:0] ACOP_OFS_CLEAR    = 8'h04;  // write one to clear, write only
    localparam logic [7:0] ACOP_OFS_ENABLE   = 8'h08;  // interrupt enables
    localparam logic [7:0] ACOP_OFS_MODE     = 8'h0C;  // decoded strap and power state
    localparam logic [7:0] ACOP_OFS_COUNT    = 8'h10;  // words delivered
    localparam logic [7:0] ACOP_OFS_LASTWORD = 8'h14;  // last word and over-range

    // ************************************************************
    // event bit positions (status, clear and enable share them)
    // ************************************************************
    localparam int ACOP_EVT_WORD  = 0;  // a word was presented
    localparam int ACOP_EVT_OVR   = 1;  // a word was out of range
    localparam int ACOP_EVT_POWER = 2;  // power-down input changed
    localparam int ACOP_EVT_W     = 3;  // number of event bits

    // ************************************************************
    // mode register field positions
    // ************************************************************
    localparam int ACOP_MODE_DIFF  = 0;  // differential clock selected
    localparam int ACOP_MODE_TWOS  = 1;  // two's complement selected
    localparam int ACOP_MODE_PDOWN = 2;  // block is powered down

    // ************************************************************
    // four-level strap codes, from ground up to full supply
    // ************************************************************
    localparam logic [1:0] ACOP_STRAP_GND   = 2'h0;  // single-ended, offset binary
    localparam logic [1:0] ACOP_STRAP_THIRD = 2'h1;  // single-ended, two's complement
    localparam logic [1:0] ACOP_STRAP_TWO3  = 2'h2;  // differential, offset binary
    localparam logic [1:0] ACOP_STRAP_FULL  = 2'h3;  // differential, two's complement

    // ************************************************************
    // conversion range and reset values
    // ************************************************************
    localparam logic [15:0] ACOP_CODE_MAX   = 16'h3FFF;   // top code 16383
    localparam logic [13:0] ACOP_WORD_RST   = 14'h0000;   // word after reset
    localparam logic [2:0]  ACOP_EVT_RST    = 3'h0;       // status and enables
    localparam logic [31:0] ACOP_RDATA_RST  = 32'h0000_0000;
    localparam logic [15:0] ACOP_COUNT_RST  = 16'h0000;

endpackage

// file: core/acop_sync.sv
// two-stage synchroniser for inputs that come from outside the clock domain
`timescale 1ns/1ps

module acop_sync #(
    parameter int WIDTH = 1  // number of bits synchronised side by side
) (
    // clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    // asynchronous side
    input  wire logic [WIDTH-1:0] async_i,
    // synchronised side
    output logic      [WIDTH-1:0] sync_o
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [WIDTH-1:0] stage1;  // may be metastable, read only by stage2
        logic [WIDTH-1:0] stage2;  // safe to use
    } acop_sync_s;

    acop_sync_s state_q;  // registered state
    acop_sync_s state_d;  // next state

    // next state: plain shift, nothing looks at stage1 but stage2
    always_comb
    begin
        state_d        = state_q;
        state_d.stage1 = async_i;
        state_d.stage2 = state_q.stage1;
    end

    // register the state, cleared by the synchronous reset
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign sync_o = state_q.stage2;

endmodule // acop_sync

// file: core/acop_core.sv
// converter configuration strap, power-down and output word port
//
// Summary of operation
// [RQ1] sample on falling edge of sampling clock
// [RQ2] strap picks clock mode and format
// [RQ3] power-down high stops conversion, low runs
// [RQ4] fourteen-bit word, bit zero least significant
// [RQ5] over-range flag when outside 0..16383
// [RQ6] ready strobe follows clock, one word each
// [RQ7] capture logic latches on ready rising edge
// [RQ8] two's complement inverts offset binary top bit
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps

module acop_core #(
    parameter int SAMPLE_W = 16  // width of the signed input amplitude
) (
    // clock and reset
    input  wire logic                clk_sys_i,
    input  wire logic                rst_i,
    // sampling clock pins
    input  wire logic                clk_pos_i,
    input  wire logic                clk_neg_i,
    // configuration pins
    input  wire logic [1:0]          clock_format_strap_i,
    input  wire logic                power_down_input_i,
    // amplitude held by the front end, signed, range 0..16383 is legal
    input  wire logic [SAMPLE_W-1:0] sample_level_i,
    // output port to capture logic
    output logic      [13:0]         result_word_o,
    output logic                     over_range_flag_o,
    output logic                     data_ready_strobe_o,
    // register port
    input  wire logic [7:0]          reg_addr_i,
    input  wire logic [31:0]         reg_wdata_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    output logic      [31:0]         reg_rdata_o,
    // interrupt
    output logic                     irq_o
);

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic {
        mode_run,    // converting on every falling edge
        mode_sleep   // only reference kept alive, no words
    } acop_mode_e;

    typedef struct packed {
        acop_mode_e                      mode;      // power state
        logic                            clk_prev;  // sampling clock last cycle
        logic                            data_ready_strobe;      // ready strobe level
        logic [13:0]                     word;      // presented word
        logic                            over_range_flag;       // presented over-range
        logic [acop_pkg::ACOP_EVT_W-1:0] status;    // sticky events
        logic [acop_pkg::ACOP_EVT_W-1:0] irq_en;    // interrupt enables
        logic [31:0]                     rdata;     // read answer
        logic [15:0]                     count;     // words delivered
        logic                            pd_prev;   // power-down last cycle
    } acop_state_s;

    localparam int SYNC_W = SAMPLE_W + 5;  // clock pair, power-down, strap, sample

    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic [SYNC_W-1:0]   sync_in;     // raw pins gathered
    logic [SYNC_W-1:0]   sync_out;    // after two flip-flops
    logic                clk_pos_s;   // synchronised positive clock pin
    logic                clk_neg_s;   // synchronised negative clock pin
    logic                pd_s;        // synchronised power-down
    logic [1:0]          strap_s;     // synchronised strap level
    logic [SAMPLE_W-1:0] sample_s;    // synchronised amplitude

    // the bench holds the amplitude steady around the falling edge,
    // so a plain two-flop stage is enough for the multi-bit sample
    assign sync_in = {clk_pos_i, clk_neg_i, power_down_input_i,
                      clock_format_strap_i, sample_level_i};

    acop_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .async_i   (sync_in),
        .sync_o    (sync_out)
    );

    assign clk_pos_s = sync_out[SYNC_W-1];
    assign clk_neg_s = sync_out[SYNC_W-2];
    assign pd_s      = sync_out[SYNC_W-3];
    assign strap_s   = sync_out[SAMPLE_W+1:SAMPLE_W];
    assign sample_s  = sync_out[SAMPLE_W-1:0];

    // ************************************************************
    // functions
    // ************************************************************

    // strap level to differential clock select
    function automatic logic strap_is_diff(input logic [1:0] s);
        strap_is_diff = (s == acop_pkg::ACOP_STRAP_FULL) ||
                        (s == acop_pkg::ACOP_STRAP_TWO3); // RQ2
    endfunction

    // strap level to two's complement select
    function automatic logic strap_is_twos(input logic [1:0] s);
        strap_is_twos = (s == acop_pkg::ACOP_STRAP_FULL) ||
                        (s == acop_pkg::ACOP_STRAP_THIRD); // RQ2
    endfunction

    // register read mux, shared by the read path
    function automatic logic [31:0] read_value(
        input logic [7:0]  addr,
        input acop_state_s s,
        input logic [1:0]  strap
    );
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (addr)
            acop_pkg::ACOP_OFS_STATUS:
            begin
                v[acop_pkg::ACOP_EVT_W-1:0] = s.status;
            end
            acop_pkg::ACOP_OFS_ENABLE:
            begin
                v[acop_pkg::ACOP_EVT_W-1:0] = s.irq_en;
            end
            acop_pkg::ACOP_OFS_MODE:
            begin
                v[acop_pkg::ACOP_MODE_DIFF]  = strap_is_diff(strap);
                v[acop_pkg::ACOP_MODE_TWOS]  = strap_is_twos(strap);
                v[acop_pkg::ACOP_MODE_PDOWN] = (s.mode == mode_sleep);
            end
            acop_pkg::ACOP_OFS_COUNT:
            begin
                v[15:0] = s.count;
            end
            acop_pkg::ACOP_OFS_LASTWORD:
            begin
                v[13:0] = s.word;
                v[16]   = s.over_range_flag;
            end
            default:
            begin
                // clear register and unmapped offsets read as zero
                v = 32'h0000_0000;
            end
        endcase
        read_value = v;
    endfunction

    // ************************************************************
    // state and combinational helpers
    // ************************************************************
    acop_state_s state_q;      // registered state
    acop_state_s state_d;      // next state
    logic        diff_mode;    // differential clock selected
    logic        twos_mode;    // two's complement selected
    logic        clk_level;    // sampling clock as the receiver sees it
    logic        clk_fall;     // falling edge seen this cycle
    logic        clk_rise;     // rising edge seen this cycle
    logic        sample_low;   // amplitude below code 0
    logic        sample_high;  // amplitude above code 16383
    logic [13:0] offset_code;  // clamped offset binary code
    logic [acop_pkg::ACOP_EVT_W-1:0] evt_set;  // events this cycle
    logic [acop_pkg::ACOP_EVT_W-1:0] evt_clr;  // clears this cycle

    // strap decode is live, so a strap moved while running takes effect
    // at the next word; real parts only read it at power-up
    assign diff_mode = strap_is_diff(strap_s); // RQ2
    assign twos_mode = strap_is_twos(strap_s); // RQ2

    // differential receiver: high when the positive pin is above the negative
    assign clk_level = diff_mode ? (clk_pos_s & ~clk_neg_s) : clk_pos_s; // RQ2
    assign clk_fall  = state_q.clk_prev & ~clk_level; // RQ1
    assign clk_rise  = ~state_q.clk_prev & clk_level;

    // range check on the signed amplitude
    assign sample_low  = sample_s[SAMPLE_W-1]; // RQ5
    assign sample_high = ~sample_s[SAMPLE_W-1] &&
                         ($unsigned(sample_s) > SAMPLE_W'(acop_pkg::ACOP_CODE_MAX)); // RQ5

    // clamp into the fourteen-bit range, saturating at the ends
    always_comb
    begin
        if (sample_low)
        begin
            offset_code = 14'h0000;
        end
        else if (sample_high)
        begin
            offset_code = acop_pkg::ACOP_CODE_MAX[13:0];
        end
        else
        begin
            offset_code = sample_s[13:0];
        end
    end

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb
    begin
        state_d  = state_q;
        evt_set  = '0;
        evt_clr  = '0;

        // edge tracking runs in every mode so wake-up sees no false edge
        state_d.clk_prev = clk_level;
        state_d.pd_prev  = pd_s;

        // power state follows the input level directly
        unique case (state_q.mode)
            mode_run:
            begin
                if (pd_s)
                begin
                    state_d.mode = mode_sleep; // RQ3
                    state_d.data_ready_strobe = 1'b0;       // strobe parked low while asleep
                end
                else if (clk_fall)
                begin
                    // take the sample and present it as the strobe falls
                    state_d.word = twos_mode ?
                        {~offset_code[13], offset_code[12:0]} : offset_code; // RQ8 RQ4
                    state_d.over_range_flag   = sample_low | sample_high; // RQ5
                    state_d.data_ready_strobe  = 1'b0;  // RQ6
                    state_d.count = state_q.count + 16'h0001;
                    evt_set[acop_pkg::ACOP_EVT_WORD] = 1'b1;
                    evt_set[acop_pkg::ACOP_EVT_OVR]  = sample_low | sample_high;
                end
                else if (clk_rise)
                begin
                    // word has been stable for half a period by now
                    state_d.data_ready_strobe = 1'b1; // RQ6 RQ7
                end
            end
            mode_sleep:
            begin
                // last word and flag hold; no sampling while asleep
                if (!pd_s)
                begin
                    state_d.mode = mode_run; // RQ3
                end
            end
        endcase

        // a change on the power-down input is an event
        evt_set[acop_pkg::ACOP_EVT_POWER] = pd_s ^ state_q.pd_prev;

        // register writes
        if (reg_wr_i)
        begin
            if (reg_addr_i == acop_pkg::ACOP_OFS_CLEAR)
            begin
                evt_clr = reg_wdata_i[acop_pkg::ACOP_EVT_W-1:0];
            end
            else if (reg_addr_i == acop_pkg::ACOP_OFS_ENABLE)
            begin
                state_d.irq_en = reg_wdata_i[acop_pkg::ACOP_EVT_W-1:0];
            end
        end

        // set wins over clear so no event slips past a clear
        state_d.status = (state_q.status & ~evt_clr) | evt_set;

        // read answer stands only in the cycle after the strobe
        state_d.rdata = reg_rd_i ? read_value(reg_addr_i, state_q, strap_s)
                                 : acop_pkg::ACOP_RDATA_RST;
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            state_q.mode     <= mode_run;
            state_q.clk_prev <= 1'b0;
            state_q.data_ready_strobe     <= 1'b0;
            state_q.word     <= acop_pkg::ACOP_WORD_RST;
            state_q.over_range_flag      <= 1'b0;
            state_q.status   <= acop_pkg::ACOP_EVT_RST;
            state_q.irq_en   <= acop_pkg::ACOP_EVT_RST;
            state_q.rdata    <= acop_pkg::ACOP_RDATA_RST;
            state_q.count    <= acop_pkg::ACOP_COUNT_RST;
            state_q.pd_prev  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign result_word_o       = state_q.word;  // RQ4
    assign over_range_flag_o   = state_q.over_range_flag;
    assign data_ready_strobe_o = state_q.data_ready_strobe;
    assign reg_rdata_o         = state_q.rdata;
    assign irq_o               = |(state_q.status & state_q.irq_en);

endmodule // acop_core

// file: sim/acop_core_assertions.sv
// concurrent checks on the converter output port and register port
`timescale 1ns/1ps

module acop_core_assertions #(
    parameter int SAMPLE_W = 16  // width of the amplitude input
) (
    // clock and reset
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    // pins watched
    input wire logic        clk_pos_i,
    input wire logic [1:0]  clock_format_strap_i,
    input wire logic        power_down_input_i,
    input wire logic [13:0] result_word_o,
    input wire logic        over_range_flag_o,
    input wire logic        data_ready_strobe_o,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic        irq_o
);
    // ************************************************************
    // properties, all in the system clock domain
    // ************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    // word may only move while the strobe is low, so capture sees it settled
    chk_word_strobe_low: assert property (
        $changed(result_word_o) |-> !data_ready_strobe_o) else $error("word moved on high strobe");
    // a new word follows a low sampling clock three cycles back
    chk_word_after_fall: assert property (
        $changed(result_word_o) && ($past(clock_format_strap_i, 3) ==
        $past(clock_format_strap_i, 4)) |-> !$past(clk_pos_i, 3))
        else $error("word not tied to a falling clock");
    // strobe rise follows a high sampling clock
    chk_strobe_rise: assert property (
        $rose(data_ready_strobe_o) |-> $past(clk_pos_i, 3)) else $error("strobe rose early");
    // strobe falls on a low clock or on power-down
    chk_strobe_fall: assert property (
        $fell(data_ready_strobe_o) |-> !$past(clk_pos_i, 3) || $past(power_down_input_i, 3))
        else $error("strobe fell without cause");
    // power-down held keeps the strobe quiet
    chk_pdown_quiet: assert property (
        power_down_input_i [*5] |-> !data_ready_strobe_o) else $error("strobe in power-down");
    // power-down held freezes the word
    chk_pdown_hold: assert property (
        power_down_input_i [*5] |-> $stable(result_word_o)) else $error("word moved asleep");
    // an out-of-range word is clamped to an end code, either format
    chk_ovr_clamped: assert property (
        over_range_flag_o |-> result_word_o inside {14'h0000, 14'h3FFF, 14'h2000, 14'h1FFF})
        else $error("over-range word not clamped");
    // read data only in the cycle after a read strobe
    chk_rdata_idle: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000) else $error("stray read data");
    // interrupt only drops after a clear or enable write
    chk_irq_drop: assert property (
        $fell(irq_o) |-> $past(reg_wr_i)) else $error("irq dropped by itself");
endmodule // acop_core_assertions

bind acop_core acop_core_assertions #(.SAMPLE_W(SAMPLE_W)) u_chk (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .clk_pos_i(clk_pos_i),
    .clock_format_strap_i(clock_format_strap_i), .power_down_input_i(power_down_input_i),
    .result_word_o(result_word_o), .over_range_flag_o(over_range_flag_o),
    .data_ready_strobe_o(data_ready_strobe_o), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));

// file: sim/acop_capture_model.sv
// downstream capture logic latching words on the ready strobe
`timescale 1ns/1ps

module acop_capture_model (
    // port from the converter
    input  wire logic        data_ready_strobe_i,
    input  wire logic [13:0] result_word_i,
    input  wire logic        over_range_flag_i,
    // captured view for the bench
    output logic      [13:0] cap_word_o,
    output logic             cap_ovr_o,
    output logic      [15:0] cap_n_o
);
    logic [15:0] n_q = 16'h0000;  // words captured, one driver only
    assign cap_n_o = n_q;
    // latch on the rising strobe only; the word is settled then
    always @(posedge data_ready_strobe_i)
    begin
        cap_word_o <= result_word_i;
        cap_ovr_o  <= over_range_flag_i;
        n_q        <= n_q + 16'h0001;
    end
endmodule // acop_capture_model

// file: sim/test_acop_core.sv
// self-checking bench for the converter configuration and output port
`timescale 1ns/1ps
`define CHK(g, e) check_val(32'(g), 32'(e))

module test_acop_core;
    // ************************************************************
    // signals
    // ************************************************************
    logic        clk = 1'b0;  // system clock, 40 ns
    logic        rst = 1'b1;
    logic        clk_pos = 1'b0;  // free-running sampling clock
    logic        clk_neg;
    logic        diff_on = 1'b0;  // bench drives a true complement
    logic        neg_same = 1'b0;  // broken pair, level never high
    logic [1:0]  strap = acop_pkg::ACOP_STRAP_GND;
    logic        pdown = 1'b1;  // asleep until the format test
    logic [15:0] sample = 16'h0000;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata, rd_v;
    logic [13:0] word, cap_word, w0;
    logic        over_range_flag, strobe, irq, cap_ovr;
    logic [15:0] cap_n, n0;
    int          error_cnt = 0;
    int          n_compared = 0;
    logic [15:0] vals [7] = '{16'h0000, 16'h0001, 16'h1FFF, 16'h2000, 16'h3FFF,
                              16'h4000, 16'hFFFF};

    always #20 clk = ~clk;
    // sampling clock with its own phase, 320 ns
    initial
    begin
        #13;
        forever #160 clk_pos = ~clk_pos;
    end
    // negative pin: grounded, complement, or copy to break differential mode
    assign clk_neg = neg_same ? clk_pos : (diff_on ? ~clk_pos : 1'b0);

    acop_core #(.SAMPLE_W(16)) uut (
        .clk_sys_i(clk), .rst_i(rst), .clk_pos_i(clk_pos), .clk_neg_i(clk_neg),
        .clock_format_strap_i(strap), .power_down_input_i(pdown), .sample_level_i(sample),
        .result_word_o(word), .over_range_flag_o(over_range_flag), .data_ready_strobe_o(strobe),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .irq_o(irq));
    acop_capture_model u_cap (
        .data_ready_strobe_i(strobe), .result_word_i(word), .over_range_flag_i(over_range_flag),
        .cap_word_o(cap_word), .cap_ovr_o(cap_ovr), .cap_n_o(cap_n));

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe edge; taken at its closing edge
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
    // present a level before a falling edge, wait for the capture after it
    task automatic put_sample(input logic [15:0] v);
        logic [15:0] n;
        @(posedge clk_pos);
        @(posedge clk);
        sample <= v;
        @(negedge clk_pos);
        n = cap_n;
        for (int k = 0; k < 20 && cap_n === n; k++) @(posedge clk);
        `CHK(cap_n, n + 16'h0001);
    endtask
    // clamped offset code, top bit turned over for two's complement
    function automatic logic [13:0] exp_word(input logic [15:0] v, input logic twos);
        logic [13:0] o;
        o = v[15] ? 14'h0000 : (v > acop_pkg::ACOP_CODE_MAX ? 14'h3FFF : v[13:0]);
        return twos ? (o ^ 14'h2000) : o;
    endfunction
    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // watchdog, the tests need some 800 cycles
    initial
    begin
        #(40 * 60000);
        error_cnt++;
        summarize();
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        // reset values, read-only mode, unmapped place
        reg_read(acop_pkg::ACOP_OFS_ENABLE, rd_v); `CHK(rd_v, acop_pkg::ACOP_EVT_RST);
        reg_read(acop_pkg::ACOP_OFS_COUNT, rd_v); `CHK(rd_v, acop_pkg::ACOP_COUNT_RST);
        reg_read(acop_pkg::ACOP_OFS_MODE, rd_v); `CHK(rd_v, 32'h0000_0004);
        reg_write(acop_pkg::ACOP_OFS_MODE, 32'h0000_0003);
        reg_read(acop_pkg::ACOP_OFS_MODE, rd_v); `CHK(rd_v, 32'h0000_0004);
        reg_read(8'h20, rd_v); `CHK(rd_v, 32'h0000_0000);
        reg_read(acop_pkg::ACOP_OFS_CLEAR, rd_v); `CHK(rd_v, 32'h0000_0000);
        $display("test reset values done");
        // every strap level, boundary and out-of-range levels
        pdown <= 1'b0;
        for (int s = 0; s < 4; s++)
        begin
            strap <= 2'(s);
            diff_on <= (s >= 2);
            repeat (8) @(posedge clk);
            reg_read(acop_pkg::ACOP_OFS_MODE, rd_v);
            `CHK(rd_v[2:0], {1'b0, s[0], s[1]});
            for (int i = 0; i < 7; i++)
            begin
                put_sample(vals[i]);
                `CHK(cap_word, exp_word(vals[i], s[0]));
                `CHK(cap_ovr, vals[i][15] || vals[i] > 16'h3FFF);
            end
        end
        $display("test formats done");
        // differential mode with a broken pair gives no words;
        // break it while the clock is low so the level shows no false fall
        @(negedge clk_pos);
        @(posedge clk);
        neg_same <= 1'b1;
        repeat (6) @(posedge clk);
        n0 = cap_n;
        repeat (48) @(posedge clk);
        `CHK(cap_n, n0);
        // single-ended mode ignores the negative pin
        strap <= acop_pkg::ACOP_STRAP_THIRD;
        put_sample(16'h0123);
        `CHK(cap_word, 14'h2123);
        neg_same <= 1'b0;
        diff_on <= 1'b0;
        $display("test clock modes done");
        // power-down: no strobe, word held, power event flagged;
        // clear just after a fall so no word event lands behind the clear
        @(negedge clk_pos);
        repeat (3) @(posedge clk);
        reg_write(acop_pkg::ACOP_OFS_CLEAR, 32'h0000_0007);
        pdown <= 1'b1;
        repeat (8) @(posedge clk);
        n0 = cap_n;
        w0 = word;
        repeat (80) @(posedge clk);
        `CHK(cap_n, n0);
        `CHK(strobe, 1'b0);
        `CHK(word, w0);
        reg_read(acop_pkg::ACOP_OFS_MODE, rd_v); `CHK(rd_v[2], 1'b1);
        reg_read(acop_pkg::ACOP_OFS_STATUS, rd_v); `CHK(rd_v[2:0], 3'h4);
        pdown <= 1'b0;
        put_sample(16'h0005);
        `CHK(cap_word, 14'h2005);
        $display("test power-down done");
        // interrupt raised, masked, cleared
        reg_write(acop_pkg::ACOP_OFS_ENABLE, 32'h0000_0002);
        reg_write(acop_pkg::ACOP_OFS_CLEAR, 32'h0000_0007);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0);
        put_sample(16'h7000);
        reg_read(acop_pkg::ACOP_OFS_STATUS, rd_v); `CHK(rd_v[1:0], 2'h3);
        reg_read(acop_pkg::ACOP_OFS_LASTWORD, rd_v); `CHK(rd_v, 32'h0001_1FFF);
        `CHK(irq, 1'b1);
        reg_write(acop_pkg::ACOP_OFS_ENABLE, 32'h0000_0001);
        reg_write(acop_pkg::ACOP_OFS_ENABLE, 32'h0000_0002);
        reg_read(acop_pkg::ACOP_OFS_ENABLE, rd_v); `CHK(rd_v, 32'h0000_0002);
        put_sample(16'h0010);
        reg_write(acop_pkg::ACOP_OFS_CLEAR, 32'h0000_0002);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0);
        reg_write(acop_pkg::ACOP_OFS_ENABLE, 32'h0000_0000);
        $display("test interrupt done");
        summarize();
    end
endmodule // test_acop_core
